// file: tb/fcc_flash_model.sv
// Behavioural flash array answering line fetches
`timescale 1ns/100ps
`default_nettype none
module fcc_flash_model (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic [15:0] flash_addr, // Line address
  input wire logic flash_rd, // Fetch active
  output logic [127:0] flash_rdata, // Line data
  output logic [31:0] fetch_count // Lines fetched
);
  logic [127:0] last_reg;
  logic [15:0] addr_q;
  logic rd_q;
  function automatic logic [127:0] line_of(input logic [15:0] a);
    line_of = {a, 16'h0003, a, 16'h0002, a, 16'h0001, a, 16'h0000};
  endfunction
  // Outside a fetch the data bus shows the inverse of the last fetched line, never the line itself
  assign flash_rdata = flash_rd ? line_of(flash_addr) : ~last_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_reg <= 128'h0;
      addr_q <= 16'h0;
      rd_q <= 1'b0;
      fetch_count <= 32'h0;
    end else begin
      rd_q <= flash_rd;
      addr_q <= flash_addr;
      if (flash_rd) begin
        last_reg <= line_of(flash_addr);
      end
      if (flash_rd && (!rd_q || flash_addr != addr_q)) begin
        fetch_count <= fetch_count + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/fcc_top_assertions.sv
// Port checks for the flash read controller
`timescale 1ns/100ps
`default_nettype none
`include "fcc_regs.vh"
module fcc_chk (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB data
  input wire logic hsel, // AHB select
  input wire logic [19:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB type
  input wire logic hready, // AHB ready in
  input wire logic hreadyout, // AHB ready out
  input wire logic hresp, // AHB error
  input wire logic flash_rd, // Fetch active
  input wire logic flash_main_en, // Main power
  input wire logic flash_hv_en, // HV power
  input wire logic pe_req, // Program request
  input wire logic [19:0] pe_addr, // Program address
  input wire logic pe_grant, // Program grant
  input wire logic [10:0] pe_row // Program row
);
  // ============
  // Helpers
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [3:0] ws_reg;
  logic [7:0] run_reg;
  wire logic acc = hsel && htrans[1] && hready && hreadyout;
  wire logic pw = psel && penable && pwrite;
  function automatic logic [1:0] sec(input logic [19:0] a);
    sec = (a < `FCC_APP_S1_BASE) ? `FCC_RGN_S0 : (a < `FCC_APP_END) ? `FCC_RGN_S1 :
      (a >= `FCC_SUP_BASE && a < `FCC_SUP_END) ? `FCC_RGN_SUP : `FCC_RGN_HOLE;
  endfunction
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ws_reg <= `FCC_WS_RST;
      run_reg <= 8'h00;
    end else begin
      if (pw && paddr == `FCC_CTL_OFF)
        ws_reg <= pwdata[3:0];
      run_reg <= flash_rd ? run_reg + 8'h01 : 8'h00;
    end
  end
  // ============
  // Properties
  property p_hole_err;
    acc && sec(haddr) == `FCC_RGN_HOLE |=> !hreadyout ##1 (hresp && !hreadyout) ##1 (hresp && hreadyout);
  endproperty
  a_hole_err: assert property (p_hole_err) else $error("hole read not refused");
  property p_busy_err;
    acc && pe_req && pe_grant && sec(haddr) == sec(pe_addr) |=> ##1 hresp;
  endproperty
  a_busy_err: assert property (p_busy_err) else $error("busy sector read not refused");
  property p_err_pair;
    hresp && !hreadyout |=> hresp && hreadyout;
  endproperty
  a_err_pair: assert property (p_err_pair) else $error("error response not two cycles");
  property p_rd_hold;
    flash_rd |-> !hreadyout;
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("ready high during fetch");
  property p_ws_len;
    $fell(flash_rd) |-> run_reg == ws_reg + 1 || run_reg == 2 * (ws_reg + 1);
  endproperty
  a_ws_len: assert property (p_ws_len) else $error("fetch length not wait states plus one");
  property p_pwr_wr;
    pw && paddr == `FCC_PWR_OFF |=> flash_main_en == $past(pwdata[0]) && flash_hv_en == $past(pwdata[1]);
  endproperty
  a_pwr_wr: assert property (p_pwr_wr) else $error("power enables do not follow write");
  property p_off_err;
    acc && !flash_main_en && !flash_hv_en |=> ##1 hresp;
  endproperty
  a_off_err: assert property (p_off_err) else $error("read of powered down flash not refused");
  property p_row;
    $past(presetn) |-> pe_row == $past(pe_addr[19:9]);
  endproperty
  a_row: assert property (p_row) else $error("row index wrong");
  property p_grant;
    pe_grant |-> $past(pe_req) && sec($past(pe_addr)) != `FCC_RGN_HOLE;
  endproperty
  a_grant: assert property (p_grant) else $error("grant without valid request");
  c_hole: cover property (acc && sec(haddr) == `FCC_RGN_HOLE);
  c_fetch: cover property ($fell(flash_rd));
  c_grant: cover property (pe_grant);
  c_off: cover property (!flash_main_en && !flash_hv_en);
endmodule
bind fcc_top fcc_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .hsel, .haddr, .htrans,
  .hready, .hreadyout, .hresp, .flash_rd, .flash_main_en, .flash_hv_en, .pe_req, .pe_addr, .pe_grant, .pe_row);
`default_nettype wire

// file: tb/flash_read_controller_cache_tb_top.sv
// Self-checking bench for the flash read controller
`timescale 1ns/100ps
`default_nettype none
`include "fcc_regs.vh"
module flash_read_controller_cache_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, pe_req = 1'b0, deep_sleep = 1'b0, e, hr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, q, hd, r, c0;
  logic [19:0] haddr = 20'h0, pe_addr = 20'h0, a;
  logic [1:0] htrans = 2'h0;
  logic [3:0] hmaster = 4'h0;
  wire logic [31:0] prdata, hrdata, fcnt;
  wire logic pready, pslverr, hreadyout, hresp, flash_rd, flash_main_en, flash_hv_en, pe_grant;
  wire logic [15:0] flash_addr;
  wire logic [127:0] flash_rdata;
  wire logic [10:0] pe_row;
  wire logic hready = hreadyout;
  int fail_count = 0, n_compared = 0, cyc = 0, k;
  int lru_l[8] = '{0, 1, 2, 3, 0, 4, 0, 1};
  int lru_m[8] = '{1, 1, 1, 1, 0, 1, 0, 1};
  fcc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .hsel,
    .haddr, .htrans, .hwrite, .hmaster, .hready, .hrdata, .hreadyout, .hresp, .flash_addr, .flash_rd,
    .flash_rdata, .flash_main_en, .flash_hv_en, .pe_req, .pe_addr, .pe_grant, .pe_row, .deep_sleep);
  fcc_flash_model u_flash (.pclk, .presetn, .flash_addr, .flash_rd, .flash_rdata, .fetch_count(fcnt));
  initial forever #4 pclk = ~pclk;
  // ============
  // Tasks
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(q, exp, "register");
  endtask
  task automatic ahb(input logic [19:0] ad, input logic [3:0] m);
    @(posedge pclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= ad;
    hmaster <= m;
    do @(posedge pclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    do @(posedge pclk); while (hreadyout !== 1'b1);
    hd = hrdata;
    hr = hresp;
  endtask
  function automatic logic [31:0] ew(input logic [19:0] ad);
    ew = {ad[19:4], 14'h0, ad[3:2]};
  endfunction
  task automatic rdx(input logic [19:0] ad, input logic [3:0] m, input logic err);
    ahb(ad, m);
    chk(hr, err, "response");
    if (!err) chk(hd, ew(ad), "read data");
  endtask
  task automatic rc(input logic [19:0] ad, input logic [3:0] m, input logic [31:0] inc);
    c0 = fcnt;
    rdx(ad, m, 1'b0);
    chk(fcnt - c0, inc, "fetch count");
  endtask
  task automatic wait_ready();
    do apb(1'b0, `FCC_STAT_OFF, 32'h0); while (q[0] !== 1'b1);
    chk(q[0], 1'b1, "power ready");
  endtask
  task automatic pe_try(input logic [19:0] ad, input logic g);
    pe_addr <= ad;
    pe_req <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(pe_grant, g, "grant");
  endtask
  // ============
  // Main sequence
  initial begin
    void'($urandom(91113));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`FCC_CTL_OFF, {23'h0, `FCC_UNLOCK_RST, 4'h0, `FCC_WS_RST});
    rdc(`FCC_PWR_OFF, {30'h0, `FCC_PWR_HV_RST, `FCC_PWR_MAIN_RST});
    rdc(`FCC_CA0_OFF, {`FCC_CACHE_ENABLE_BIT_RST, `FCC_PF_EN_RST, 30'h0});
    rdc(`FCC_CA1_OFF, {`FCC_CACHE_ENABLE_BIT_RST, `FCC_PF_EN_RST, 30'h0});
    apb(1'b0, 12'h018, 32'h0);
    chk(e, 1'b1, "unmapped");
    rdx(20'h00100, 4'h2, 1'b1);
    wait_ready();
    $display("test reset finished");
    for (k = 0; k < 16; k++) begin
      r = $urandom_range(4, 0);
      apb(1'b1, `FCC_CTL_OFF, r);
      r = $urandom;
      a = r[27] ? {5'h10, r[14:2], 2'h0} : {2'h0, r[17:2], 2'h0};
      rdx(a, {1'b0, r[30:28]}, 1'b0);
    end
    $display("test random finished");
    apb(1'b1, `FCC_CMD_OFF, 32'h3);
    foreach (lru_l[i]) rc(20'h01000 + 20'(lru_l[i] << 11), 4'h0, lru_m[i]);
    rc(20'h01000, 4'h1, 32'h1);
    apb(1'b1, `FCC_CA0_OFF, 32'h0);
    rc(20'h01000, 4'h0, 32'h1);
    apb(1'b1, `FCC_CA0_OFF, 32'hc000_0000);
    apb(1'b1, `FCC_CMD_OFF, 32'h3);
    rc(20'h02004, 4'h0, 32'h2);
    rc(20'h02018, 4'h0, 32'h0);
    $display("test cache finished");
    rdx(20'h40000, 4'h0, 1'b1);
    rdx(20'h88000, 4'h3, 1'b1);
    pe_try(20'h20200, 1'b1);
    chk(pe_row, 11'h101, "row");
    rdx(20'h20400, 4'h2, 1'b1);
    rdx(20'h00400, 4'h2, 1'b0);
    apb(1'b1, `FCC_CMD_OFF, 32'h3);
    rdx(20'h1fff4, 4'h0, 1'b1);
    rdx(20'h1fff4, 4'h1, 1'b0);
    pe_try(20'h80000, 1'b0);
    apb(1'b1, `FCC_CTL_OFF, 32'h103);
    pe_try(20'h80000, 1'b1);
    pe_req <= 1'b0;
    $display("test busy finished");
    apb(1'b1, `FCC_PWR_OFF, 32'h0);
    @(posedge pclk);
    chk({flash_hv_en, flash_main_en}, 2'b00, "power off");
    rdx(20'h00100, 4'h2, 1'b1);
    apb(1'b1, `FCC_PWR_OFF, 32'h3);
    rdx(20'h00100, 4'h2, 1'b1);
    wait_ready();
    rdx(20'h00100, 4'h2, 1'b0);
    rc(20'h03000, 4'h1, 32'h1);
    deep_sleep <= 1'b1;
    repeat (4) @(posedge pclk);
    deep_sleep <= 1'b0;
    rdc(`FCC_CTL_OFF, 32'h103);
    rc(20'h03000, 4'h1, 32'h0);
    $display("test power finished");
    wrap_up();
  end
endmodule
`default_nettype wire

// file: verilog/fcc_cache.v
// Four-way set-associative 8 kB line cache with true LRU replacement
`timescale 1ns/100ps
`default_nettype none

module fcc_cache (
  input wire pclk,               // Bus clock
  input wire presetn,            // Asynchronous reset, active low
  input wire cache_en,           // Cache enable
  input wire inval,              // Invalidate all lines
  input wire [19:0] look_addr,   // Byte offset being looked up or filled
  output wire hit,               // Valid way with matching tag
  output wire [127:0] hit_line,  // Line of the hitting way
  input wire touch,              // Mark hitting way most recent
  input wire fill,               // Write fill_line into victim way
  input wire [127:0] fill_line   // Line to fill
);

  reg [3:0] valid_mem [0:127];
  reg [7:0] lru_mem [0:127];
  reg [8:0] tag_mem [0:511];
  reg [127:0] data_mem [0:511];
  wire [6:0] set_idx;
  wire [8:0] tag;
  wire [3:0] way_hit;
  wire [1:0] hit_way;
  wire [1:0] vict_way;
  integer i;

  assign set_idx = look_addr[10:4];
  assign tag = look_addr[19:11];

  // ============
  // Helpers
  function [1:0] enc4;
    input [3:0] v;
    begin
      enc4 = v[3] ? 2'h3 : v[2] ? 2'h2 : v[1] ? 2'h1 : 2'h0;
    end
  endfunction

  // Ages 0 (newest) to 3 (oldest); the used way becomes 0, younger ones age
  function [7:0] lru_upd;
    input [7:0] ages;
    input [1:0] used;
    reg [1:0] ua;
    reg [1:0] a;
    integer k;
    begin
      ua = ages[used*2 +: 2];
      lru_upd = ages;
      for (k = 0; k < 4; k = k + 1) begin
        a = ages[k*2 +: 2];
        if (k == used)
          lru_upd[k*2 +: 2] = 2'h0;
        else if (a < ua)
          lru_upd[k*2 +: 2] = a + 2'h1;
      end
    end
  endfunction

  function [1:0] oldest;
    input [7:0] ages;
    integer k;
    begin
      oldest = 2'h0;
      for (k = 0; k < 4; k = k + 1) begin
        if (ages[k*2 +: 2] == 2'h3)
          oldest = k[1:0];
      end
    end
  endfunction

  // ============
  // Lookup across all ways of the set
  genvar w;
  generate
    for (w = 0; w < 4; w = w + 1) begin : g_way
      localparam [1:0] WI = w;
      assign way_hit[w] = valid_mem[set_idx][w] && (tag_mem[{set_idx, WI}] == tag);
    end
  endgenerate

  assign hit = cache_en && (|way_hit);
  assign hit_way = enc4(way_hit);
  assign hit_line = data_mem[{set_idx, hit_way}];
  // Prefer an empty way, otherwise the least recently used one
  assign vict_way = (&valid_mem[set_idx]) ? oldest(lru_mem[set_idx]) : enc4(~valid_mem[set_idx]);

  // ============
  // Valid bits and ages; kept across deep sleep, both reset by reset, only valid bits cleared by command
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 128; i = i + 1) begin
        valid_mem[i] <= 4'h0;
        lru_mem[i] <= 8'he4;
      end
    end else begin
      if (inval) begin
        for (i = 0; i < 128; i = i + 1)
          valid_mem[i] <= 4'h0;
      end
      if (fill) begin
        valid_mem[set_idx][vict_way] <= 1'b1;
        lru_mem[set_idx] <= lru_upd(lru_mem[set_idx], vict_way);
      end else if (touch && hit) begin
        lru_mem[set_idx] <= lru_upd(lru_mem[set_idx], hit_way);
      end
    end
  end

  always @(posedge pclk) begin
    if (fill) begin
      tag_mem[{set_idx, vict_way}] <= tag;
      data_mem[{set_idx, vict_way}] <= fill_line;
    end
  end

endmodule
`default_nettype wire

// file: verilog/fcc_regs.vh
// Register map, field positions, reset values, geometry and timing of the flash read controller
`ifndef FCC_REGS_VH
`define FCC_REGS_VH

// ============
// Register byte offsets (APB, one aligned word each)
`define FCC_CTL_OFF 12'h000
`define FCC_PWR_OFF 12'h004
`define FCC_CMD_OFF 12'h008
`define FCC_STAT_OFF 12'h00c
`define FCC_CA0_OFF 12'h010
`define FCC_CA1_OFF 12'h014

// ============
// Field positions
`define FCC_WS_MSB 3
`define FCC_WS_LSB 0
`define FCC_UNLOCK_BIT 8
`define FCC_PWR_MAIN_BIT 0
`define FCC_PWR_HV_BIT 1
`define FCC_CMD_INV_CACHE_BIT 0
`define FCC_CMD_INV_BUF_BIT 1
`define FCC_CACHE_ENABLE_BIT_BIT 31
`define FCC_PF_EN_BIT 30

// ============
// Reset values
`define FCC_WS_RST 4'h4
`define FCC_UNLOCK_RST 1'b0
`define FCC_PWR_MAIN_RST 1'b1
`define FCC_PWR_HV_RST 1'b1
`define FCC_CACHE_ENABLE_BIT_RST 1'b1
`define FCC_PF_EN_RST 1'b0

// ============
// Geometry: 512-byte rows, 128 KB application sectors, 32 KB supervisory sector
`define FCC_ROW_LSB 9
`define FCC_LINE_LSB 4
`define FCC_APP_S1_BASE 20'h20000
`define FCC_APP_END 20'h40000
`define FCC_SUP_BASE 20'h80000
`define FCC_SUP_END 20'h88000
`define FCC_RGN_S0 2'h0
`define FCC_RGN_S1 2'h1
`define FCC_RGN_SUP 2'h2
`define FCC_RGN_HOLE 2'h3

// ============
// Bus masters that own a cache
`define FCC_MST_CORE0 4'h0
`define FCC_MST_CORE1 4'h1

// ============
// Flash wakeup: 10 us at 125 MHz, in bus clock cycles
`define FCC_WAKE_CYC 11'h4e2

`endif

// file: verilog/fcc_top.v
// Flash read controller: AHB-Lite read port, per-core caches, prefetch, APB registers
//
// What this block does
// - Flash rows are 512 bytes, smallest program unit
// - Read one sector while another is written
// - Two 128 KB app sectors, one 32 KB supervisory
// - Supervisory reads allowed, program/erase restricted
// - One AHB-Lite slave port for all masters
// - Bus error on read of busy sector
// - Bus error on read of memory hole
// - Four-bit wait-state field sets flash wait cycles
// - Both power enables cleared powers flash down
// - Registers and cache survive deep sleep; buffers dropped
// - Each core has 8 kB four-way LRU cache
// - Lookup checks valid and tag in every way
// - Bit 31 of cache control enables cache
// - Cache miss served by ordinary flash access
// - Bit 30 of cache control enables prefetch
// - Miss refills line and prefetches next line
// - Prefetched line enters cache only on miss
// - Reads proceed while another sector is busy
// - Prefetch into busy next sector raises fault
`include "fcc_regs.vh"
`timescale 1ns/100ps
`default_nettype none

module fcc_top (
  input wire pclk,                // Bus clock, 125 MHz
  input wire presetn,             // Asynchronous reset, active low
  input wire psel,                // APB select
  input wire penable,             // APB access phase
  input wire pwrite,              // APB write
  input wire [11:0] paddr,        // APB byte address
  input wire [31:0] pwdata,       // APB write data
  output wire [31:0] prdata,      // APB read data
  output wire pready,             // APB ready
  output wire pslverr,            // APB error on unmapped address
  input wire hsel,                // AHB-Lite slave select
  input wire [19:0] haddr,        // AHB-Lite byte offset in flash region
  input wire [1:0] htrans,        // AHB-Lite transfer type
  input wire hwrite,              // AHB-Lite write
  input wire [3:0] hmaster,       // Requesting master id
  input wire hready,              // AHB-Lite ready in
  output wire [31:0] hrdata,      // AHB-Lite read data
  output wire hreadyout,          // AHB-Lite ready out
  output wire hresp,              // AHB-Lite error response
  output wire [15:0] flash_addr,  // Flash line address
  output wire flash_rd,           // Flash read in progress
  input wire [127:0] flash_rdata, // Flash line data
  output wire flash_main_en,      // Flash main power enable
  output wire flash_hv_en,        // Flash high voltage enable
  input wire pe_req,              // Program or erase operation requested
  input wire [19:0] pe_addr,      // Target address of program or erase
  output wire pe_grant,           // Program or erase allowed and active
  output wire [10:0] pe_row,      // Target row index
  input wire deep_sleep           // Deep sleep entered
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_CHECK = 3'h1;
  localparam [2:0] ST_FETCH = 3'h2;
  localparam [2:0] ST_PREF = 3'h3;
  localparam [2:0] ST_DONE = 3'h4;
  localparam [2:0] ST_ERR1 = 3'h5;
  localparam [2:0] ST_ERR2 = 3'h6;
  localparam [10:0] WAKE_CYC = `FCC_WAKE_CYC;

  reg [2:0] state_reg;
  reg [19:0] addr_reg;
  reg [3:0] mst_reg;
  reg wr_reg;
  reg [3:0] cnt_reg;
  reg [15:0] faddr_reg;
  reg [31:0] hrdata_reg;
  reg [31:0] prdata_reg;
  reg [3:0] ws_reg;
  reg unlock_reg;
  reg pwr_main_reg;
  reg pwr_hv_reg;
  reg [10:0] wake_reg;
  reg cache_enable_bit_reg [0:1];
  reg pf_en_reg [0:1];
  reg [1:0] pf_valid_reg;
  reg [15:0] pf_addr_mem [0:1];
  reg [127:0] pf_line_mem [0:1];
  reg pe_grant_reg;
  reg [1:0] pe_rgn_reg;
  reg [10:0] pe_row_reg;

  // ============
  // Address decode and word select
  function [1:0] region;
    input [19:0] a;
    begin
      if (a < `FCC_APP_S1_BASE)
        region = `FCC_RGN_S0;
      else if (a < `FCC_APP_END)
        region = `FCC_RGN_S1;
      else if (a >= `FCC_SUP_BASE && a < `FCC_SUP_END)
        region = `FCC_RGN_SUP;
      else
        region = `FCC_RGN_HOLE;
    end
  endfunction

  function [31:0] word_of;
    input [127:0] line;
    input [1:0] sel;
    begin
      word_of = line[sel*32 +: 32];
    end
  endfunction

  // ============
  // Request context
  wire core_sel = mst_reg[0];
  wire is_core = (mst_reg == `FCC_MST_CORE0) || (mst_reg == `FCC_MST_CORE1);
  wire ca_on = is_core && cache_enable_bit_reg[core_sel];
  wire pf_on = ca_on && pf_en_reg[core_sel];
  wire [1:0] rgn = region(addr_reg);
  wire [15:0] nxt_line = addr_reg[19:4] + 16'h0001;
  wire [1:0] nrgn = region({nxt_line, 4'h0});
  wire [3:0] busy_vec = pe_grant_reg ? (4'h1 << pe_rgn_reg) : 4'h0;
  wire busy = busy_vec[rgn];
  wire nbusy = busy_vec[nrgn];
  wire pwr_ready = (pwr_main_reg || pwr_hv_reg) && (wake_reg == 11'h000);
  wire pf_hit = pf_valid_reg[core_sel] && (pf_addr_mem[core_sel] == addr_reg[19:4]);
  wire [1:0] wsel = addr_reg[3:2];
  wire hit0;
  wire hit1;
  wire [127:0] line0;
  wire [127:0] line1;
  wire hit = core_sel ? hit1 : hit0;
  wire [127:0] hit_line = core_sel ? line1 : line0;

  // Outcome of the check cycle
  wire chk_err = wr_reg || (rgn == `FCC_RGN_HOLE) || busy || !pwr_ready;
  wire chk_hit = ca_on && hit;
  wire chk_pf = ca_on && !hit && pf_hit;
  wire chk_fault = pf_on && !hit && !pf_hit && (nrgn != `FCC_RGN_HOLE) && nbusy;
  wire in_check = (state_reg == ST_CHECK) && !chk_err;
  wire fetch_end = (state_reg == ST_FETCH) && (cnt_reg == 4'h0);
  wire touch = in_check && chk_hit;
  wire fill = (in_check && chk_pf) || (fetch_end && ca_on);
  wire [127:0] fill_line = (state_reg == ST_CHECK) ? pf_line_mem[core_sel] : flash_rdata;

  // APB decode
  wire apb_wr = psel && penable && pwrite;
  wire sel_ctl = (paddr == `FCC_CTL_OFF);
  wire sel_pwr = (paddr == `FCC_PWR_OFF);
  wire sel_cmd = (paddr == `FCC_CMD_OFF);
  wire sel_stat = (paddr == `FCC_STAT_OFF);
  wire sel_ca0 = (paddr == `FCC_CA0_OFF);
  wire sel_ca1 = (paddr == `FCC_CA1_OFF);
  wire mapped = sel_ctl || sel_pwr || sel_cmd || sel_stat || sel_ca0 || sel_ca1;
  wire inv_cache = apb_wr && sel_cmd && pwdata[`FCC_CMD_INV_CACHE_BIT];
  wire inv_buf = (apb_wr && sel_cmd && pwdata[`FCC_CMD_INV_BUF_BIT]) || deep_sleep;

  // AHB handshake
  assign hreadyout = (state_reg == ST_IDLE) || (state_reg == ST_DONE) || (state_reg == ST_ERR2);
  assign hresp = (state_reg == ST_ERR1) || (state_reg == ST_ERR2);
  assign hrdata = hrdata_reg;
  wire accept = hsel && htrans[1] && hready && hreadyout;

  // ============
  // Per-core caches
  fcc_cache u_cache0 (
    .pclk(pclk),
    .presetn(presetn),
    .cache_en(cache_enable_bit_reg[0]),
    .inval(inv_cache),
    .look_addr(addr_reg),
    .hit(hit0),
    .hit_line(line0),
    .touch(touch && !core_sel),
    .fill(fill && !core_sel),
    .fill_line(fill_line)
  );

  fcc_cache u_cache1 (
    .pclk(pclk),
    .presetn(presetn),
    .cache_en(cache_enable_bit_reg[1]),
    .inval(inv_cache),
    .look_addr(addr_reg),
    .hit(hit1),
    .hit_line(line1),
    .touch(touch && core_sel),
    .fill(fill && core_sel),
    .fill_line(fill_line)
  );

  // ============
  // Read state machine
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      addr_reg <= 20'h00000;
      mst_reg <= 4'h0;
      wr_reg <= 1'b0;
      cnt_reg <= 4'h0;
      faddr_reg <= 16'h0000;
      hrdata_reg <= 32'h00000000;
    end else if (deep_sleep) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE, ST_DONE, ST_ERR2: begin
          if (accept) begin
            addr_reg <= haddr;
            mst_reg <= hmaster;
            wr_reg <= hwrite;
            state_reg <= ST_CHECK;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        ST_CHECK: begin
          if (chk_err) begin
            state_reg <= ST_ERR1;
          end else if (chk_hit) begin
            hrdata_reg <= word_of(hit_line, wsel);
            state_reg <= ST_DONE;
          end else if (chk_pf) begin
            hrdata_reg <= word_of(pf_line_mem[core_sel], wsel);
            state_reg <= ST_DONE;
          end else if (chk_fault) begin
            state_reg <= ST_ERR1;
          end else begin
            faddr_reg <= addr_reg[19:4];
            cnt_reg <= ws_reg;
            state_reg <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (cnt_reg == 4'h0) begin
            hrdata_reg <= word_of(flash_rdata, wsel);
            if (pf_on && (nrgn != `FCC_RGN_HOLE)) begin
              faddr_reg <= nxt_line;
              cnt_reg <= ws_reg;
              state_reg <= ST_PREF;
            end else begin
              state_reg <= ST_DONE;
            end
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        ST_PREF: begin
          if (cnt_reg == 4'h0)
            state_reg <= ST_DONE;
          else
            cnt_reg <= cnt_reg - 4'h1;
        end
        ST_ERR1: begin
          state_reg <= ST_ERR2;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  assign flash_addr = faddr_reg;
  assign flash_rd = (state_reg == ST_FETCH) || (state_reg == ST_PREF);

  // ============
  // Prefetch buffers; a new line wins over a same-cycle invalidate command, but not over deep sleep
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pf_valid_reg <= 2'h0;
    end else begin
      if (inv_buf)
        pf_valid_reg <= 2'h0;
      else if (in_check && chk_pf)
        pf_valid_reg[core_sel] <= 1'b0;
      if ((state_reg == ST_PREF) && (cnt_reg == 4'h0) && !deep_sleep)
        pf_valid_reg[core_sel] <= 1'b1;
    end
  end

  always @(posedge pclk) begin
    if ((state_reg == ST_PREF) && (cnt_reg == 4'h0)) begin
      pf_addr_mem[core_sel] <= faddr_reg;
      pf_line_mem[core_sel] <= flash_rdata;
    end
  end

  // ============
  // Program and erase gate: hole never, supervisory only when unlocked
  wire [1:0] pe_rgn = region(pe_addr);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pe_grant_reg <= 1'b0;
      pe_rgn_reg <= `FCC_RGN_HOLE;
      pe_row_reg <= 11'h000;
    end else begin
      pe_grant_reg <= pe_req && (pe_rgn != `FCC_RGN_HOLE) && ((pe_rgn != `FCC_RGN_SUP) || unlock_reg);
      pe_rgn_reg <= pe_rgn;
      pe_row_reg <= pe_addr[19:`FCC_ROW_LSB];
    end
  end

  assign pe_grant = pe_grant_reg;
  assign pe_row = pe_row_reg;

  // ============
  // Power enables and wakeup counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      wake_reg <= WAKE_CYC;
    else if (!(pwr_main_reg || pwr_hv_reg))
      wake_reg <= WAKE_CYC;
    else if (wake_reg != 11'h000)
      wake_reg <= wake_reg - 11'h001;
  end

  assign flash_main_en = pwr_main_reg;
  assign flash_hv_en = pwr_hv_reg;

  // ============
  // APB registers, kept across deep sleep
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ws_reg <= `FCC_WS_RST;
      unlock_reg <= `FCC_UNLOCK_RST;
      pwr_main_reg <= `FCC_PWR_MAIN_RST;
      pwr_hv_reg <= `FCC_PWR_HV_RST;
      cache_enable_bit_reg[0] <= `FCC_CACHE_ENABLE_BIT_RST;
      cache_enable_bit_reg[1] <= `FCC_CACHE_ENABLE_BIT_RST;
      pf_en_reg[0] <= `FCC_PF_EN_RST;
      pf_en_reg[1] <= `FCC_PF_EN_RST;
    end else if (apb_wr) begin
      if (sel_ctl) begin
        ws_reg <= pwdata[`FCC_WS_MSB:`FCC_WS_LSB];
        unlock_reg <= pwdata[`FCC_UNLOCK_BIT];
      end
      if (sel_pwr) begin
        pwr_main_reg <= pwdata[`FCC_PWR_MAIN_BIT];
        pwr_hv_reg <= pwdata[`FCC_PWR_HV_BIT];
      end
      if (sel_ca0) begin
        cache_enable_bit_reg[0] <= pwdata[`FCC_CACHE_ENABLE_BIT_BIT];
        pf_en_reg[0] <= pwdata[`FCC_PF_EN_BIT];
      end
      if (sel_ca1) begin
        cache_enable_bit_reg[1] <= pwdata[`FCC_CACHE_ENABLE_BIT_BIT];
        pf_en_reg[1] <= pwdata[`FCC_PF_EN_BIT];
      end
    end
  end

  // Read data is sampled in the setup cycle and held through the access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= 32'h00000000;
      if (sel_ctl)
        prdata_reg <= {23'h000000, unlock_reg, 4'h0, ws_reg};
      if (sel_pwr)
        prdata_reg <= {30'h00000000, pwr_hv_reg, pwr_main_reg};
      if (sel_stat)
        prdata_reg <= {25'h0000000, pf_valid_reg, pe_grant_reg, busy_vec[2:0], pwr_ready};
      if (sel_ca0)
        prdata_reg <= {cache_enable_bit_reg[0], pf_en_reg[0], 30'h00000000};
      if (sel_ca1)
        prdata_reg <= {cache_enable_bit_reg[1], pf_en_reg[1], 30'h00000000};
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

endmodule
`default_nettype wire
